/* logic/dag_pkg.sv */
// Constants and register map for the dual address generator
// What this block does
// [R1] Two separate generators, X and Y, each form an address in the same cycle.
// [R2] Y generator serves only word reads of multiply-accumulate instructions; all else uses X.
// [R3] Addressing kinds are exactly linear, circular and bit-reversed.
// [R4] Linear and circular addressing work for data and program space addresses.
// [R5] Bit reversal applies to data space only, never to program addresses.
// [R6] Start and end boundaries sit in 16-bit registers, one pair per generator (X and Y).
// [R7] Buffer length follows from end minus start, at most 32K words.
// [R8] Y circular addresses are word sized, address bit zero kept clear.
// [R9] Only power-of-two buffers check both boundaries; others wrap one direction.
// [R10] Mode control holds X and Y circular enables and three pointer selects.
package dag_pkg;
  localparam int DAG_AW = 16;
  localparam logic [7:0] DAG_OFS_MODE = 8'h46;
  localparam logic [7:0] DAG_OFS_XS = 8'h48;
  localparam logic [7:0] DAG_OFS_XE = 8'h4A;
  localparam logic [7:0] DAG_OFS_YS = 8'h4C;
  localparam logic [7:0] DAG_OFS_YE = 8'h4E;
  localparam logic [7:0] DAG_OFS_BR = 8'h50;
  localparam int DAG_BIT_XEN = 15;
  localparam int DAG_BIT_YEN = 14;
  localparam int DAG_POS_RSEL = 8;
  localparam int DAG_POS_YSEL = 4;
  localparam int DAG_POS_XSEL = 0;
  localparam int DAG_BIT_REN = 15;
  localparam logic [15:0] DAG_MODE_RST = 16'h0000;
  localparam logic [15:0] DAG_BND_RST = 16'h0000;
  localparam logic [15:0] DAG_BR_RST = 16'h0000;
  localparam logic [15:0] DAG_MAX_LEN_WORDS = 16'h8000;
  typedef enum logic [1:0] {DAG_LINEAR, DAG_CIRCULAR, DAG_REVERSE} dag_kind_e;
endpackage : dag_pkg

/* logic/dag_top.sv */
// Dual X/Y effective address generator with Wishbone register port
`timescale 1ns/1ps
module dag_top
  import dag_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic x_req,
  input wire logic [3:0] x_reg,
  input wire logic [15:0] x_ptr,
  input wire logic signed [15:0] x_mod,
  input wire logic x_prog,
  input wire logic y_req,
  input wire logic y_mac_word_read,
  input wire logic [3:0] y_reg,
  input wire logic [15:0] y_ptr,
  input wire logic signed [15:0] y_mod,
  output logic x_valid,
  output logic [15:0] x_ea,
  output logic [15:0] x_next_ptr,
  output logic [1:0] x_kind,
  output logic y_valid,
  output logic [15:0] y_ea,
  output logic [15:0] y_next_ptr,
  output logic [1:0] y_kind,
  output logic y_refused
);
  logic [15:0] circular_mode_control;
  logic [15:0] x_circular_start;
  logic [15:0] x_circular_end;
  logic [15:0] y_circular_start;
  logic [15:0] y_circular_end;
  logic [15:0] bit_reverse_control;
  logic x_circular_enable;
  logic y_circular_enable;
  logic reverse_enable;
  logic [3:0] x_pointer_select;
  logic [3:0] y_pointer_select;
  logic [3:0] reverse_pointer_select;
  logic [14:0] reverse_modifier;
  logic bus_req;
  logic hit;
  logic [15:0] rd_word;

  assign x_circular_enable = circular_mode_control[DAG_BIT_XEN]; // [R10]
  assign y_circular_enable = circular_mode_control[DAG_BIT_YEN];
  assign reverse_pointer_select = circular_mode_control[DAG_POS_RSEL +: 4];
  assign y_pointer_select = circular_mode_control[DAG_POS_YSEL +: 4];
  assign x_pointer_select = circular_mode_control[DAG_POS_XSEL +: 4];
  assign reverse_enable = bit_reverse_control[DAG_BIT_REN];
  assign reverse_modifier = bit_reverse_control[14:0];

  // Circular step; start bit0 is forced low and end bit0 high, so length = end - start + 1 stays even
  function automatic logic [15:0] wrap(input logic [15:0] p, input logic signed [15:0] m,
                                       input logic [15:0] s, input logic [15:0] e);
    logic [15:0] n;
    logic [15:0] len;
    logic pow2;
    n = p + m;
    len = e - s + 16'h0001; // [R7]
    pow2 = ((len & (len - 16'h0001)) == 16'h0000);
    wrap = n;
    if (m >= 0 && n > e && p <= e) begin
      wrap = n - len;
    end else if (m < 0 && n < s && p >= s && pow2) begin
      wrap = n + len; // [R9]
    end
  endfunction : wrap

  // Reverse-carry add of the modifier, shifted left one bit, to the pointer
  function automatic logic [15:0] rev_add(input logic [15:0] p, input logic [14:0] m);
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] r;
    logic c;
    c = 1'b0;
    a = {<<{p}};
    b = {<<{m, 1'b0}};
    for (int i = 0; i < 16; i++) begin
      r[i] = a[i] ^ b[i] ^ c;
      c = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
    end
    rev_add = {<<{r}};
  endfunction : rev_add

  logic x_circ;
  logic x_rev;
  logic y_ok;
  logic y_circ;
  logic [15:0] next_x_ptr;
  logic [15:0] next_y_ptr;

  assign x_circ = x_circular_enable && (x_reg == x_pointer_select); // [R4]
  assign x_rev = reverse_enable && !x_prog && (x_reg == reverse_pointer_select); // [R5]
  assign y_ok = y_req && y_mac_word_read; // [R2]
  assign y_circ = y_circular_enable && (y_reg == y_pointer_select);

  always_comb begin
    if (x_rev) begin
      next_x_ptr = rev_add(x_ptr, reverse_modifier); // [R3]
    end else if (x_circ) begin
      next_x_ptr = wrap(x_ptr, x_mod, x_circular_start, x_circular_end);
    end else begin
      next_x_ptr = x_ptr + x_mod;
    end
  end

  always_comb begin
    if (y_circ) begin
      next_y_ptr = wrap(y_ptr, y_mod, y_circular_start, y_circular_end) & 16'hFFFE; // [R8]
    end else begin
      next_y_ptr = y_ptr + y_mod;
    end
  end

  // X generator, independent of Y
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      x_valid <= 1'b0;
      x_ea <= 16'h0000;
      x_next_ptr <= 16'h0000;
      x_kind <= 2'h0;
    end else begin
      x_valid <= x_req; // [R1]
      if (x_req) begin
        x_ea <= x_ptr;
        x_next_ptr <= next_x_ptr;
        x_kind <= x_rev ? DAG_REVERSE : (x_circ ? DAG_CIRCULAR : DAG_LINEAR);
      end
    end
  end

  // Y generator, same cycle as X
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      y_valid <= 1'b0;
      y_ea <= 16'h0000;
      y_next_ptr <= 16'h0000;
      y_kind <= 2'h0;
      y_refused <= 1'b0;
    end else begin
      y_valid <= y_ok; // [R1]
      y_refused <= y_req && !y_mac_word_read; // [R2]
      if (y_ok) begin
        y_ea <= y_ptr & 16'hFFFE;
        y_next_ptr <= next_y_ptr;
        y_kind <= y_circ ? DAG_CIRCULAR : DAG_LINEAR;
      end
    end
  end

  // Wishbone slave: one wait state, ack drops after one cycle
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign hit = (wb_adr_i == DAG_OFS_MODE) || (wb_adr_i == DAG_OFS_XS) || (wb_adr_i == DAG_OFS_XE) ||
               (wb_adr_i == DAG_OFS_YS) || (wb_adr_i == DAG_OFS_YE) || (wb_adr_i == DAG_OFS_BR);

  always_comb begin
    case (wb_adr_i)
      DAG_OFS_MODE: rd_word = circular_mode_control;
      DAG_OFS_XS: rd_word = x_circular_start;
      DAG_OFS_XE: rd_word = x_circular_end;
      DAG_OFS_YS: rd_word = y_circular_start;
      DAG_OFS_YE: rd_word = y_circular_end;
      DAG_OFS_BR: rd_word = bit_reverse_control;
      default: rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req && hit;
      wb_err_o <= bus_req && !hit;
      wb_dat_o <= (bus_req && hit && !wb_we_i) ? {16'h0000, rd_word} : 32'h00000000;
    end
  end

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  logic wr;
  assign wr = bus_req && hit && wb_we_i;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      circular_mode_control <= DAG_MODE_RST;
      x_circular_start <= DAG_BND_RST;
      x_circular_end <= DAG_BND_RST;
      y_circular_start <= DAG_BND_RST;
      y_circular_end <= DAG_BND_RST;
      bit_reverse_control <= DAG_BR_RST;
    end else if (wr) begin
      case (wb_adr_i)
        DAG_OFS_MODE: circular_mode_control <= merge(circular_mode_control, wb_dat_i, wb_sel_i) & 16'hCFFF;
        DAG_OFS_XS: x_circular_start <= merge(x_circular_start, wb_dat_i, wb_sel_i) & 16'hFFFE; // [R6]
        DAG_OFS_XE: x_circular_end <= merge(x_circular_end, wb_dat_i, wb_sel_i) | 16'h0001;
        DAG_OFS_YS: y_circular_start <= merge(y_circular_start, wb_dat_i, wb_sel_i) & 16'hFFFE;
        DAG_OFS_YE: y_circular_end <= merge(y_circular_end, wb_dat_i, wb_sel_i) | 16'h0001;
        DAG_OFS_BR: bit_reverse_control <= merge(bit_reverse_control, wb_dat_i, wb_sel_i);
        default: bit_reverse_control <= bit_reverse_control;
      endcase
    end
  end
endmodule : dag_top

/* tb/dag_top_properties.sv */
// Checker for bus and generator timing
`timescale 1ns/1ps
module dag_top_properties(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic x_req,
  input wire logic [15:0] x_ptr,
  input wire logic x_prog,
  input wire logic x_valid,
  input wire logic [15:0] x_ea,
  input wire logic [1:0] x_kind,
  input wire logic y_req,
  input wire logic y_mac_word_read,
  input wire logic y_valid,
  input wire logic [15:0] y_ea,
  input wire logic y_refused
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
  sequence s_yserve; y_req && y_mac_word_read; endsequence
  AST_BUS_ANSWER: assert property (s_take |=> wb_ack_o != wb_err_o) else $error("no bus answer");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_X_VALID: assert property (x_valid == $past(x_req)) else $error("x valid late");
  AST_X_EA: assert property (x_req |=> x_ea == $past(x_ptr)) else $error("x address wrong");
  AST_BOTH: assert property (x_req && y_req && y_mac_word_read |=> x_valid && y_valid) else $error("not parallel");
  AST_Y_SERVE: assert property (s_yserve |=> y_valid && !y_refused) else $error("y not served");
  AST_Y_REFUSE: assert property (y_req && !y_mac_word_read |=> y_refused && !y_valid) else $error("y not refused");
  AST_KIND: assert property (x_valid |-> x_kind != 2'h3) else $error("bad kind");
  AST_PROG: assert property (x_req && x_prog |=> x_kind != 2'h2) else $error("program reversed");
  AST_Y_EVEN: assert property (y_valid |-> !y_ea[0]) else $error("y odd");
endmodule : dag_top_properties
bind dag_top dag_top_properties dag_top_properties_inst(.*);

/* tb/dag_core_model.sv */
// Pipeline model: pointer file, request issue, write-back
`timescale 1ns/1ps
module dag_core_model(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic go_x,
  input wire logic go_y,
  input wire logic mac,
  input wire logic prog,
  input wire logic [3:0] sel,
  input wire logic [15:0] step,
  input wire logic x_valid,
  input wire logic [15:0] x_next_ptr,
  output logic x_req,
  output logic y_req,
  output logic y_mac_word_read,
  output logic x_prog,
  output logic [3:0] x_reg,
  output logic [15:0] x_ptr,
  output logic [15:0] x_mod
);
  logic [15:0] wreg [16];
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {x_req, y_req, y_mac_word_read, x_prog, x_reg, x_ptr, x_mod} <= '0;
    end else begin
      x_req <= go_x;
      y_req <= go_y;
      y_mac_word_read <= mac;
      x_prog <= prog;
      x_reg <= sel;
      x_ptr <= wreg[sel];
      x_mod <= step;
      // Updated pointer lands back in the file
      if (x_valid) wreg[x_reg] <= x_next_ptr;
    end
  end
endmodule : dag_core_model

/* tb/test_dag_top.sv */
// Self-checking bench for the dual address generator
`timescale 1ns/1ps
module test_dag_top;
  import dag_pkg::*;
  logic core_clk = 1'h0, rst_n = 1'h0, wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, go_x = 1'h0, go_y = 1'h0;
  logic mac = 1'h0, prog = 1'h0, wb_ack_o, wb_err_o, x_req, x_prog, y_req, y_mac_word_read, x_valid, y_valid, y_refused;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [3:0] wb_sel_i = 4'h3, sel = 4'h0, x_reg;
  logic [15:0] step = 16'h0, x_ptr, x_mod, x_ea, x_next_ptr, y_ea, y_next_ptr;
  logic [1:0] x_kind, y_kind;
  wire [15:0] y_ptr = x_ptr, y_mod = x_mod;
  wire [3:0] y_reg = x_reg;
  int error_cnt = 0, n_checks = 0;
  dag_top dag_top_inst(.*);
  dag_core_model dag_core_model_inst(.*);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d, input logic [15:0] e, input logic er);
    int i;
    i = 0;
    {wb_cyc_i, wb_stb_i, wb_adr_i, wb_we_i, wb_dat_i} <= {2'h3, a, w, 16'h0, d};
    do @(posedge core_clk); while (!(wb_ack_o | wb_err_o) && ++i < 20);
    check(wb_ack_o | wb_err_o, 1'h1);
    if (!(wb_ack_o | wb_err_o)) test_done();
    if (!w) check(wb_dat_o, {16'h0, e});
    check(wb_err_o, er);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge core_clk);
  endtask : wb
  // Request, then one cycle to valid; the return sees the valid cycle
  task automatic gen(input logic gx, input logic gy, input logic m, input logic p, input logic [3:0] s,
                     input logic [15:0] st);
    {go_x, go_y, mac, prog, sel, step} <= {gx, gy, m, p, s, st};
    @(posedge core_clk);
    {go_x, go_y} <= 2'h0;
    repeat (2) @(posedge core_clk);
  endtask : gen
  task automatic t_regs();
    wb(DAG_OFS_MODE, 1'h0, 16'h0, DAG_MODE_RST, 1'h0);
    wb(DAG_OFS_MODE, 1'h1, 16'hB5A3, 16'h0, 1'h0);
    wb(DAG_OFS_MODE, 1'h0, 16'h0, 16'h85A3, 1'h0);
    wb(DAG_OFS_XS, 1'h1, 16'h1001, 16'h0, 1'h0);
    wb(DAG_OFS_XS, 1'h0, 16'h0, 16'h1000, 1'h0);
    wb(DAG_OFS_XE, 1'h1, 16'h100E, 16'h0, 1'h0);
    wb(DAG_OFS_XE, 1'h0, 16'h0, 16'h100F, 1'h0);
    wb(DAG_OFS_BR, 1'h1, 16'h8001, 16'h0, 1'h0);
    wb(8'h52, 1'h0, 16'h0, 16'h0, 1'h1);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_gen();
    gen(1'h1, 1'h0, 1'h0, 1'h0, 4'h1, 16'h0004);
    check({x_valid, x_ea, x_next_ptr, x_kind}, {1'h1, 16'h2000, 16'h2004, 2'h0});
    gen(1'h0, 1'h1, 1'h1, 1'h0, 4'h2, 16'h0002);
    check({y_valid, y_refused, y_ea}, {2'h2, 16'h3002});
    check({y_next_ptr, y_kind}, {16'h3005, 2'h0});
    gen(1'h0, 1'h1, 1'h0, 1'h0, 4'h2, 16'h0002);
    check({y_valid, y_refused}, 2'h1);
    gen(1'h1, 1'h1, 1'h1, 1'h0, 4'h1, 16'h0002);
    check({x_valid, y_valid, x_ea, y_ea}, {2'h3, 16'h2004, 16'h2004});
    gen(1'h1, 1'h0, 1'h0, 1'h0, 4'h3, 16'h0002);
    check({x_next_ptr, x_kind}, {16'h1000, 2'h1});
    gen(1'h1, 1'h0, 1'h0, 1'h0, 4'h3, 16'hFFFE);
    check({x_next_ptr, x_kind}, {16'h100E, 2'h1});
    gen(1'h1, 1'h0, 1'h0, 1'h1, 4'h3, 16'h0002);
    check({x_next_ptr, x_kind}, {16'h1000, 2'h1});
    gen(1'h1, 1'h0, 1'h0, 1'h0, 4'h5, 16'h0002);
    check({x_ea, x_next_ptr, x_kind}, {16'h0040, 16'h0042, 2'h2});
    // Pointer 5 came back as 0x0042; reversed carry would give 0x0041
    gen(1'h1, 1'h0, 1'h0, 1'h1, 4'h5, 16'h0002);
    check({x_ea, x_next_ptr, x_kind}, {16'h0042, 16'h0044, 2'h0});
    $display("t_gen done");
  endtask : t_gen
  task automatic t_ycirc();
    wb(DAG_OFS_YS, 1'h1, 16'h3001, 16'h0, 1'h0);
    wb(DAG_OFS_YS, 1'h0, 16'h0, 16'h3000, 1'h0);
    wb(DAG_OFS_YE, 1'h1, 16'h3006, 16'h0, 1'h0);
    wb(DAG_OFS_YE, 1'h0, 16'h0, 16'h3007, 1'h0);
    wb(DAG_OFS_MODE, 1'h1, 16'hC5A3, 16'h0, 1'h0);
    wb(DAG_OFS_MODE, 1'h0, 16'h0, 16'hC5A3, 1'h0);
    gen(1'h0, 1'h1, 1'h1, 1'h0, 4'hA, 16'h0002);
    check({y_ea, y_next_ptr}, {16'h3006, 16'h3000});
    check({y_valid, y_kind}, {1'h1, 2'h1});
    // Odd step inside the buffer must still leave an even pointer
    gen(1'h0, 1'h1, 1'h1, 1'h0, 4'hA, 16'h0001);
    check({y_next_ptr, y_kind}, {16'h3006, 2'h1});
    $display("t_ycirc done");
  endtask : t_ycirc
  task automatic t_reset();
    rst_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    check({x_valid, y_valid, y_refused, wb_ack_o}, 4'h0);
    wb(DAG_OFS_MODE, 1'h0, 16'h0, DAG_MODE_RST, 1'h0);
    wb(DAG_OFS_YE, 1'h0, 16'h0, DAG_BND_RST, 1'h0);
    wb(DAG_OFS_BR, 1'h0, 16'h0, DAG_BR_RST, 1'h0);
    gen(1'h1, 1'h0, 1'h0, 1'h0, 4'h1, 16'h0002);
    check({x_ea, x_next_ptr}, {16'h2006, 16'h2008});
    check(x_kind, 2'h0);
    $display("t_reset done");
  endtask : t_reset
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    dag_core_model_inst.wreg[1] = 16'h2000;
    dag_core_model_inst.wreg[2] = 16'h3003;
    dag_core_model_inst.wreg[3] = 16'h100E;
    dag_core_model_inst.wreg[5] = 16'h0040;
    dag_core_model_inst.wreg[10] = 16'h3006;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    t_regs();
    t_gen();
    t_ycirc();
    t_reset();
    test_done();
  end
endmodule : test_dag_top
